// ### shared/cor_regs.svh
// constants for the corrected-output request link: counts and limits
// assumes a 200 MHz CLK_IN on both ends
`ifndef COR_REGS_SVH
`define COR_REGS_SVH

`define COR_CLK_MHZ 200
`define COR_RST_MIN_NS 300
`define COR_RST_CYC ((`COR_RST_MIN_NS * `COR_CLK_MHZ + 999) / 1000)
`define COR_POST_RST_NS 300
`define COR_POST_RST_CYC ((`COR_POST_RST_NS * `COR_CLK_MHZ + 999) / 1000)
`define COR_TICK_US 1
`define COR_TICK_CYC (`COR_TICK_US * `COR_CLK_MHZ)
`define COR_READ_WIN_MS 8
`define COR_READ_WIN_TICKS (`COR_READ_WIN_MS * 1000 / `COR_TICK_US)
`define COR_OSC_SETTLE_MS 10
`define COR_OSC_SETTLE_CYC (`COR_OSC_SETTLE_MS * 1000 * `COR_CLK_MHZ)
`define COR_VBLK_PER_FRAME 190
`define COR_SYNC_W 6

`endif

// ### shared/cor_pkg.sv
// types shared by both ends of the corrected-output request link
// assumes nothing beyond the constants header
package cor_pkg;
   typedef enum logic [1:0]
   {
      COR_MODE_DEFAULT = 2'h0,
      COR_MODE_1 = 2'h1,
      COR_MODE_2 = 2'h2,
      COR_MODE_3 = 2'h3
   } cor_mode_t;

   typedef enum logic [1:0]
   {
      COR_REQ_IDLE = 2'h0,
      COR_REQ_WAIT = 2'h1,
      COR_REQ_READ = 2'h3
   } cor_req_st_t;

   typedef enum logic [2:0]
   {
      COR_HST_PWR_RST = 3'h0,
      COR_HST_POST = 3'h1,
      COR_HST_RUN = 3'h3,
      COR_HST_STBY = 3'h2,
      COR_HST_SETTLE = 3'h6
   } cor_host_st_t;
endpackage

// ### shared/cor_link_if.sv
// pins between the receiver end and the host controller end
// the data-ready line is open drain with a pull-up, resolved here
`timescale 1ns/1ps
interface cor_link_if;
   logic chip_rst_b;
   logic standby_pin;
   logic req_timing_sel;
   logic vertical_output_select;
   logic drdy_ind_en;
   logic read_busy;
   logic block_req_b;
   logic drdy_b_o;
   logic drdy_b_oe;
   logic drdy_b;

   assign drdy_b = drdy_b_oe ? drdy_b_o : 1'b1;

   modport dev
   (
      input chip_rst_b, standby_pin, req_timing_sel,
      input vertical_output_select, drdy_ind_en, read_busy,
      output block_req_b, drdy_b_o, drdy_b_oe
   );

   modport host
   (
      output chip_rst_b, standby_pin, req_timing_sel,
      output vertical_output_select, drdy_ind_en, read_busy,
      input block_req_b, drdy_b
   );
endinterface

// ### hw/cor_dev.sv
// receiver end: block release, request pin, data-ready indicator
// assumes the link pins come from another clock domain and are synced
`timescale 1ns/1ps
`include "cor_regs.svh"

module cor_dev
#(
   parameter int unsigned READ_WIN_TICKS = `COR_READ_WIN_TICKS
)
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   cor_link_if.dev LINK,
   input wire logic BLK_READY_IN,
   input wire logic BLK_H_OK_IN,
   input wire logic FRAME_START_IN,
   input wire logic VSLOT_IN,
   input wire logic VSLOT_OK_IN,
   output logic RELEASE_OUT,
   output logic RELEASE_VERT_OUT,
   output logic CORE_RESET_OUT,
   output cor_pkg::cor_mode_t MODE_OUT
);
   import cor_pkg::*;

   localparam int unsigned TICK_CYC = `COR_TICK_CYC;
   localparam int unsigned VBLK = `COR_VBLK_PER_FRAME;

   function automatic cor_mode_t decode_mode(input logic rts,
                                             input logic vos);
      if (rts && vos)
      begin
         decode_mode = COR_MODE_1;
      end
      else if (rts)
      begin
         decode_mode = COR_MODE_2;
      end
      else if (vos)
      begin
         decode_mode = COR_MODE_3;
      end
      else
      begin
         decode_mode = COR_MODE_DEFAULT;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [`COR_SYNC_W-1:0] sync1_q;
   logic [`COR_SYNC_W-1:0] sync2_q;
   logic rst_pin_b;
   logic stby;
   logic rts;
   logic vos;
   logic drdy_en;
   logic rd_busy;
   logic core_rst;

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end
      else
      begin
         sync1_q <= {LINK.chip_rst_b, LINK.standby_pin, LINK.req_timing_sel,
                     LINK.vertical_output_select, LINK.drdy_ind_en,
                     LINK.read_busy};
         sync2_q <= sync1_q;
      end
   end

   assign rst_pin_b = sync2_q[5];
   assign stby = sync2_q[4];
   assign rts = sync2_q[3];
   assign vos = sync2_q[2];
   assign drdy_en = sync2_q[1];
   assign rd_busy = sync2_q[0];
   assign core_rst = !rst_pin_b || stby;

   ////////////////////////////////////////////////////////////////////////
   // internal divider: stopped and cleared while held in reset
   logic [7:0] div_q;
   logic [7:0] div_d;
   logic tick;

   assign tick = (div_q == 8'(TICK_CYC - 1));

   always_comb
   begin
      div_d = div_q + 8'h01;
      if (core_rst || tick)
      begin
         div_d = 8'h00;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         div_q <= 8'h00;
      end
      else
      begin
         div_q <= div_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame tracking and vertical release decision
   cor_mode_t mode;
   logic hfail_q;
   logic hfail_d;
   logic prev_fail_q;
   logic prev_fail_d;
   logic [7:0] vcnt_q;
   logic [7:0] vcnt_d;
   logic vslot_live;
   logic vrel;
   logic hrel;

   assign mode = core_rst ? COR_MODE_DEFAULT
                          : decode_mode(rts, vos);
   assign vslot_live = VSLOT_IN && (vcnt_q < 8'(VBLK));
   assign hrel = BLK_READY_IN && !core_rst;

   always_comb
   begin
      unique case (mode)
         COR_MODE_1: vrel = vslot_live;
         COR_MODE_2: vrel = vslot_live && prev_fail_q;
         COR_MODE_3: vrel = vslot_live && VSLOT_OK_IN;
         COR_MODE_DEFAULT: vrel = vslot_live && VSLOT_OK_IN;
      endcase
      if (core_rst || hrel)
      begin
         vrel = 1'b0;
      end
   end

   always_comb
   begin
      hfail_d = hfail_q;
      prev_fail_d = prev_fail_q;
      vcnt_d = vcnt_q;
      if (FRAME_START_IN)
      begin
         prev_fail_d = hfail_q || (BLK_READY_IN && !BLK_H_OK_IN);
         hfail_d = 1'b0;
         vcnt_d = 8'h00;
      end
      else
      begin
         if (BLK_READY_IN && !BLK_H_OK_IN)
         begin
            hfail_d = 1'b1;
         end
         if (vslot_live)
         begin
            vcnt_d = vcnt_q + 8'h01;
         end
      end
      if (core_rst)
      begin
         hfail_d = 1'b0;
         prev_fail_d = 1'b0;
         vcnt_d = 8'(VBLK);
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         hfail_q <= 1'b0;
         prev_fail_q <= 1'b0;
         vcnt_q <= 8'(VBLK);
      end
      else
      begin
         hfail_q <= hfail_d;
         prev_fail_q <= prev_fail_d;
         vcnt_q <= vcnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request pin and data-ready indicator
   cor_req_st_t st_q;
   cor_req_st_t st_d;
   logic [15:0] win_q;
   logic [15:0] win_d;
   logic req_b_q;
   logic req_b_d;
   logic drdy_low_q;
   logic drdy_low_d;
   logic win_end;

   assign win_end = tick && (win_q == 16'(READ_WIN_TICKS - 1));

   always_comb
   begin
      st_d = st_q;
      win_d = win_q;
      req_b_d = req_b_q;
      drdy_low_d = drdy_low_q;
      unique case (st_q)
         COR_REQ_IDLE:
         begin
            win_d = 16'h0000;
         end
         COR_REQ_WAIT:
         begin
            if (tick)
            begin
               win_d = win_q + 16'h0001;
            end
            if (rd_busy)
            begin
               req_b_d = 1'b1;
               st_d = COR_REQ_READ;
            end
            else if (win_end)
            begin
               req_b_d = 1'b1;
               drdy_low_d = 1'b0;
               st_d = COR_REQ_IDLE;
            end
         end
         COR_REQ_READ:
         begin
            if (!rd_busy)
            begin
               drdy_low_d = 1'b0;
               st_d = COR_REQ_IDLE;
            end
         end
         default: st_d = COR_REQ_IDLE;
      endcase
      if (hrel || vrel)
      begin
         req_b_d = 1'b0;
         drdy_low_d = drdy_en;
         win_d = 16'h0000;
         st_d = COR_REQ_WAIT;
      end
      if (core_rst)
      begin
         st_d = COR_REQ_IDLE;
         win_d = 16'h0000;
         req_b_d = 1'b1;
         drdy_low_d = 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         st_q <= COR_REQ_IDLE;
         win_q <= 16'h0000;
         req_b_q <= 1'b1;
         drdy_low_q <= 1'b0;
         RELEASE_OUT <= 1'b0;
         RELEASE_VERT_OUT <= 1'b0;
         CORE_RESET_OUT <= 1'b1;
         MODE_OUT <= COR_MODE_DEFAULT;
      end
      else
      begin
         st_q <= st_d;
         win_q <= win_d;
         req_b_q <= req_b_d;
         drdy_low_q <= drdy_low_d;
         RELEASE_OUT <= hrel || vrel;
         RELEASE_VERT_OUT <= vrel;
         CORE_RESET_OUT <= core_rst;
         MODE_OUT <= mode;
      end
   end

   assign LINK.block_req_b = req_b_q;
   assign LINK.drdy_b_o = 1'b0;
   assign LINK.drdy_b_oe = drdy_low_q;
endmodule

// ### hw/cor_host.sv
// host controller end: reset, standby, mode bits and block reads
// assumes the request and data-ready pins arrive unsynchronised
`timescale 1ns/1ps
`include "cor_regs.svh"

module cor_host
#(
   parameter int unsigned OSC_SETTLE_CYC = `COR_OSC_SETTLE_CYC
)
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   cor_link_if.host LINK,
   input wire logic RESET_REQ_IN,
   input wire logic STANDBY_REQ_IN,
   input wire logic RTS_SEL_IN,
   input wire logic VOS_SEL_IN,
   input wire logic DRDY_EN_IN,
   input wire logic READ_START_IN,
   input wire logic READ_DONE_IN,
   output logic WRITE_OK_OUT,
   output logic BLOCK_PENDING_OUT,
   output logic DRDY_SEEN_OUT,
   output logic READING_OUT,
   output cor_pkg::cor_host_st_t STATE_OUT
);
   import cor_pkg::*;

   localparam int unsigned RST_CYC = `COR_RST_CYC;
   localparam int unsigned POST_CYC = `COR_POST_RST_CYC;

   logic [1:0] s1_q;
   logic [1:0] s2_q;
   logic req_prev_q;
   cor_host_st_t st_q;
   cor_host_st_t st_d;
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic rst_b_q;
   logic rst_b_d;
   logic stby_q;
   logic stby_d;
   logic [2:0] cfg_q;
   logic [2:0] cfg_d;
   logic pend_d;
   logic rd_d;

   ////////////////////////////////////////////////////////////////////////
   // reset, standby and write sequencing
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q + 32'h00000001;
      rst_b_d = rst_b_q;
      stby_d = stby_q;
      cfg_d = cfg_q;
      unique case (st_q)
         COR_HST_PWR_RST:
         begin
            rst_b_d = 1'b0;
            if (cnt_q >= 32'(RST_CYC))
            begin
               rst_b_d = 1'b1;
               cnt_d = 32'h00000000;
               st_d = COR_HST_POST;
            end
         end
         COR_HST_POST:
         begin
            if (cnt_q >= 32'(POST_CYC))
            begin
               st_d = COR_HST_RUN;
            end
         end
         COR_HST_RUN:
         begin
            cfg_d = {RTS_SEL_IN, VOS_SEL_IN, DRDY_EN_IN};
            if (STANDBY_REQ_IN)
            begin
               stby_d = 1'b1;
               st_d = COR_HST_STBY;
            end
         end
         COR_HST_STBY:
         begin
            cnt_d = 32'h00000000;
            if (!STANDBY_REQ_IN)
            begin
               stby_d = 1'b0;
               st_d = COR_HST_SETTLE;
            end
         end
         COR_HST_SETTLE:
         begin
            if (cnt_q >= 32'(OSC_SETTLE_CYC))
            begin
               st_d = COR_HST_RUN;
            end
         end
         default:
         begin
            st_d = COR_HST_PWR_RST;
         end
      endcase
      if (RESET_REQ_IN)
      begin
         st_d = COR_HST_PWR_RST;
         rst_b_d = 1'b0;
         stby_d = 1'b0;
         cnt_d = 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // block reads
   always_comb
   begin
      pend_d = BLOCK_PENDING_OUT;
      rd_d = READING_OUT;
      if (s2_q[1] || st_q != COR_HST_RUN)
      begin
         pend_d = 1'b0;
      end
      else if (req_prev_q)
      begin
         pend_d = 1'b1;
      end
      if (READ_START_IN && BLOCK_PENDING_OUT && !READING_OUT)
      begin
         rd_d = 1'b1;
         pend_d = 1'b0;
      end
      else if (READ_DONE_IN || st_q != COR_HST_RUN)
      begin
         rd_d = 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         s1_q <= 2'h3;
         s2_q <= 2'h3;
         req_prev_q <= 1'b1;
         st_q <= COR_HST_PWR_RST;
         cnt_q <= 32'h00000000;
         rst_b_q <= 1'b0;
         stby_q <= 1'b0;
         cfg_q <= 3'h0;
         BLOCK_PENDING_OUT <= 1'b0;
         READING_OUT <= 1'b0;
         WRITE_OK_OUT <= 1'b0;
         DRDY_SEEN_OUT <= 1'b0;
         STATE_OUT <= COR_HST_PWR_RST;
      end
      else
      begin
         s1_q <= {LINK.block_req_b, LINK.drdy_b};
         s2_q <= s1_q;
         req_prev_q <= s2_q[1];
         st_q <= st_d;
         cnt_q <= cnt_d;
         rst_b_q <= rst_b_d;
         stby_q <= stby_d;
         cfg_q <= cfg_d;
         BLOCK_PENDING_OUT <= pend_d;
         READING_OUT <= rd_d;
         WRITE_OK_OUT <= (st_d == COR_HST_RUN);
         DRDY_SEEN_OUT <= !s2_q[0];
         STATE_OUT <= st_d;
      end
   end

   assign LINK.chip_rst_b = rst_b_q;
   assign LINK.standby_pin = stby_q;
   assign LINK.req_timing_sel = cfg_q[2];
   assign LINK.vertical_output_select = cfg_q[1];
   assign LINK.drdy_ind_en = cfg_q[0];
   assign LINK.read_busy = READING_OUT;
endmodule

// ### tb/cor_monitor.sv
// wire checks on the request link between receiver and host ends
// assumes one clock and a shared async active-low reset
`timescale 1ns/1ps
module cor_monitor
#(
   parameter int unsigned READ_WIN_TICKS = 8000
)
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic chip_rst_b,
   input wire logic standby_pin,
   input wire logic drdy_ind_en,
   input wire logic read_busy,
   input wire logic block_req_b,
   input wire logic drdy_b_o,
   input wire logic drdy_b_oe,
   input wire logic drdy_b
);
   localparam int unsigned LO_MAX = (READ_WIN_TICKS + 1) * 200 + 8;
   int unsigned lo_cnt_q;
   int unsigned lo_cnt_d;
   logic req_prev_q;

   default clocking @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   ////////////////////////////////////////////////////////////////////////
   // cycles data-ready stays low with no read, restarted by each request
   always_comb
   begin
      lo_cnt_d = lo_cnt_q + 1;
      if (drdy_b || read_busy || (req_prev_q && !block_req_b))
      begin
         lo_cnt_d = 0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         lo_cnt_q <= 0;
         req_prev_q <= 1'b1;
      end
      else
      begin
         lo_cnt_q <= lo_cnt_d;
         req_prev_q <= block_req_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_req_fall;
      $fell(block_req_b);
   endsequence

   sequence s_read_end;
      $fell(read_busy) && !drdy_b && chip_rst_b;
   endsequence

   chk_drdy_follows: assert property (s_req_fall ##0 drdy_ind_en |-> !drdy_b)
      else $error("data-ready did not fall with the request");
   chk_drdy_masked: assert property (s_req_fall ##0 (!drdy_ind_en && $past(drdy_b)) |-> drdy_b)
      else $error("data-ready fell while disabled");
   chk_od_polarity: assert property (drdy_b_oe |-> !drdy_b_o)
      else $error("open drain driven high");
   chk_read_holds: assert property (read_busy && !drdy_b && chip_rst_b && !standby_pin |=> !drdy_b)
      else $error("data-ready released during a read");
   chk_read_frees: assert property (s_read_end |-> ##[1:4] drdy_b)
      else $error("data-ready not released after the read");
   chk_req_on_read: assert property ($rose(read_busy) && !block_req_b |-> ##[2:4] block_req_b)
      else $error("request not withdrawn on read");
   chk_rst_quiet: assert property (!chip_rst_b [*4] |-> block_req_b && !drdy_b_oe)
      else $error("pins active in chip reset");
   chk_stby_quiet: assert property (standby_pin [*4] |-> block_req_b && !drdy_b_oe)
      else $error("pins active in standby");
   chk_window_end: assert property (lo_cnt_q <= LO_MAX)
      else $error("unread data-ready held past the window");
   chk_rst_width: assert property ($rose(chip_rst_b) |-> !$past(chip_rst_b, 60))
      else $error("chip reset pulse too short");
   chk_drdy_with_req: assert property ($fell(drdy_b)
      |-> $fell(block_req_b))
      else $error("data-ready fell without a request");
endmodule

// ### tb/corrected_output_request_control_tb.sv
// self-checking bench: both link ends joined, user sides driven and modelled
// assumes the constants header and package are compiled first
`timescale 1ns/1ps
`include "cor_regs.svh"
module corrected_output_request_control_tb;
   import cor_pkg::*;
   localparam int unsigned WIN = 2;
   localparam int unsigned SETTLE = 50;
   logic clk, rst_b, blk_ready, blk_h_ok, frame_start, vslot, vslot_ok;
   logic release_b, release_vert, core_reset, write_ok, pending;
   logic drdy_seen, reading, reset_req, standby_req;
   logic rts, vos, drdy_en, read_start, read_done;
   cor_mode_t mode;
   cor_host_st_t hst;
   int errors = 0;
   int compares = 0;
   int seed = 32'hF13C;
   int vcnt = 0;
   int rcnt = 0;
   int cm = 0;
   int n;
   bit prev_fail = 0;

   cor_link_if cor_link_if_inst();
   cor_dev #(.READ_WIN_TICKS(WIN)) cor_dev_inst (.CLK_IN(clk),
      .RST_B_IN(rst_b), .LINK(cor_link_if_inst), .BLK_READY_IN(blk_ready),
      .BLK_H_OK_IN(blk_h_ok), .FRAME_START_IN(frame_start),
      .VSLOT_IN(vslot), .VSLOT_OK_IN(vslot_ok), .RELEASE_OUT(release_b),
      .RELEASE_VERT_OUT(release_vert), .CORE_RESET_OUT(core_reset),
      .MODE_OUT(mode));
   cor_host #(.OSC_SETTLE_CYC(SETTLE)) cor_host_inst (.CLK_IN(clk),
      .RST_B_IN(rst_b), .LINK(cor_link_if_inst), .RESET_REQ_IN(reset_req),
      .STANDBY_REQ_IN(standby_req), .RTS_SEL_IN(rts), .VOS_SEL_IN(vos),
      .DRDY_EN_IN(drdy_en), .READ_START_IN(read_start),
      .READ_DONE_IN(read_done), .WRITE_OK_OUT(write_ok),
      .BLOCK_PENDING_OUT(pending), .DRDY_SEEN_OUT(drdy_seen),
      .READING_OUT(reading), .STATE_OUT(hst));
   cor_monitor #(.READ_WIN_TICKS(WIN)) cor_monitor_inst (.CLK_IN(clk),
      .RST_B_IN(rst_b), .chip_rst_b(cor_link_if_inst.chip_rst_b),
      .standby_pin(cor_link_if_inst.standby_pin),
      .drdy_ind_en(cor_link_if_inst.drdy_ind_en),
      .read_busy(cor_link_if_inst.read_busy),
      .block_req_b(cor_link_if_inst.block_req_b),
      .drdy_b_o(cor_link_if_inst.drdy_b_o),
      .drdy_b_oe(cor_link_if_inst.drdy_b_oe),
      .drdy_b(cor_link_if_inst.drdy_b));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // counted on the falling edge, mid-cycle, so each one-cycle pulse is seen once
   always @(negedge clk)
   begin
      vcnt += (release_vert === 1'b1);
      rcnt += (release_b === 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic compare_val(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s exp %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask

   task automatic wait_for(ref logic s, input int lim, output int k);
      k = 0;
      while (s !== 1'b1 && k < lim)
      begin
         @(negedge clk);
         k++;
      end
      compare_val("wait", s, 1'b1);
   endtask

   task automatic set_mode(input bit r, input bit v, input bit e);
      rts = r;
      vos = v;
      drdy_en = e;
      cm = r ? (v ? 1 : 2) : (v ? 3 : 0);
      cyc(WIN * 200 + 250);
      compare_val("mode", mode, cm);
   endtask

   // host takes each block so the request rises before the next one
   task automatic read_block;
      wait_for(pending, 10, n);
      pulse(read_start);
      cyc(4);
      pulse(read_done);
      cyc(4);
   endtask

   task automatic run_frame(input bit hf);
      int vbase;
      int rbase;
      int exp_v;
      int i;
      pulse(frame_start);
      vbase = vcnt;
      rbase = rcnt;
      exp_v = 0;
      blk_h_ok = !hf;
      pulse(blk_ready);
      read_block;
      for (i = 0; i < 192; i++)
      begin
         vslot_ok = 1'($random(seed));
         pulse(vslot);
         if (i < 190 && (cm == 1 || (cm == 2 && prev_fail) ||
            (cm[0] == cm[1] && vslot_ok)))
         begin
            exp_v++;
            read_block;
         end
         else
         begin
            cyc(1);
         end
      end
      cyc(3);
      compare_val("vert_count", vcnt - vbase, exp_v);
      compare_val("rel_count", rcnt - rbase, exp_v + 1);
      prev_fail = hf;
   endtask

   task automatic finish_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(5 * 60000);
      errors++;
      finish_test;
   end

   initial
   begin
      {rst_b, blk_ready, blk_h_ok, frame_start, vslot, vslot_ok} = 6'h00;
      {reset_req, standby_req, rts, vos, drdy_en} = 5'h00;
      {read_start, read_done} = 2'h0;
      cyc(10);
      compare_val("rst_core", core_reset, 1'b1);
      cyc(6);
      rst_b = 1'b1;
      wait_for(write_ok, 400, n);
      // read taken: request withdrawn, data-ready held to read end
      set_mode(1'b1, 1'b1, 1'b1);
      pulse(read_start);
      compare_val("no_read", reading, 1'b0);
      blk_h_ok = 1'b1;
      pulse(blk_ready);
      wait_for(pending, 10, n);
      compare_val("drdy_seen", drdy_seen, 1'b1);
      pulse(read_start);
      compare_val("reading", reading, 1'b1);
      cyc(WIN * 200 + 300);
      compare_val("drdy_hold", cor_link_if_inst.drdy_b, 1'b0);
      compare_val("req_taken", cor_link_if_inst.block_req_b, 1'b1);
      pulse(read_done);
      cyc(6);
      compare_val("drdy_free", cor_link_if_inst.drdy_b, 1'b1);
      // no read: request pin falls, data-ready returns high by the window end
      pulse(blk_ready);
      cyc(3);
      compare_val("req_low", cor_link_if_inst.block_req_b, 1'b0);
      cyc(WIN * 200 + 250);
      compare_val("drdy_unread", cor_link_if_inst.drdy_b, 1'b1);
      for (int m = 0; m < 4; m++)
      begin
         set_mode(m[1] ^ m[0], ~m[1], 1'($random(seed)));
         for (int f = 0; f < 3; f++)
         begin
            run_frame(f[0]);
         end
      end
      // a live mode at the edge standby starts must not reach the outputs
      {rts, vos} = 2'h3;
      standby_req = 1'b1;
      cyc(10);
      compare_val("stby_core", core_reset, 1'b1);
      compare_val("stby_mode", mode, COR_MODE_DEFAULT);
      compare_val("stby_req", cor_link_if_inst.block_req_b, 1'b1);
      compare_val("stby_state", hst, COR_HST_STBY);
      standby_req = 1'b0;
      wait_for(write_ok, SETTLE + 300, n);
      compare_val("settle", n >= SETTLE, 1'b1);
      pulse(reset_req);
      cyc(4);
      compare_val("rst_again", core_reset, 1'b1);
      compare_val("rst_mode", mode, COR_MODE_DEFAULT);
      wait_for(write_ok, 400, n);
      compare_val("post_wait",
         n >= `COR_RST_CYC + `COR_POST_RST_CYC - 6, 1'b1);
      prev_fail = 1'b0;
      set_mode(1'b1, 1'b0, 1'b1);
      run_frame(1'b1);
      run_frame(1'b0);
      finish_test;
   end
endmodule
